// ### rtl/hspc_pkg.sv
// Package: address map, lane encodings, states and helpers for the host serial port
package hspc_pkg;
   localparam int ADDR_W = 15;
   localparam int PTR_W = 12;
   localparam int FIFO_BYTES = 4096;
   localparam int CMD_WRITE_BIT = 7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] LANE_SINGLE = 2'h0;
   localparam logic [1:0] LANE_DUAL = 2'h1;
   localparam logic [1:0] LANE_QUAD = 2'h2;
   localparam logic [1:0] LANE_RSVD = 2'h3;
   localparam logic [1:0] LANE_RESET = 2'h0;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [2:0] FIFO_REGION = 3'h0;
   localparam logic [14:0] REG_LANE_WIDTH = 15'h1000;
   localparam logic [14:0] REG_CMD_WR_LO = 15'h1004;
   localparam logic [14:0] REG_CMD_WR_HI = 15'h1005;
   localparam logic [14:0] REG_CMD_RD_LO = 15'h1008;
   localparam logic [14:0] REG_CMD_RD_HI = 15'h1009;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR_HI, ST_ADDR_LO, ST_DUMMY, ST_RDATA, ST_WDATA
   } hspc_state_e;

   // Bits moved per clock edge; reserved code falls back to one lane
   function automatic logic [3:0] hspc_lane_step(input logic [1:0] w);
      case (w)
         LANE_DUAL: hspc_lane_step = 4'h2;
         LANE_QUAD: hspc_lane_step = 4'h4;
         default: hspc_lane_step = 4'h1;
      endcase
   endfunction

   // Bytes pending in the ring
   function automatic logic [11:0] hspc_fill(input logic [11:0] wr, input logic [11:0] rd);
      hspc_fill = 12'(wr - rd);
   endfunction
endpackage

// ### rtl/hspc_port.sv
// Host serial slave port with command ring and engine fetch/retire handshake
`timescale 1ns/10ps
module hspc_port
   import hspc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Serial pins
   input wire logic sck,
   input wire logic cs_n,
   input wire logic data_lane_0_in,
   output logic data_lane_0_out,
   output logic data_lane_0_oe,
   input wire logic data_lane_1_in,
   output logic data_lane_1_out,
   output logic data_lane_1_oe,
   // Shared general pins, lanes 2 and 3 in quad mode
   input wire logic general_pin_0_in,
   output logic general_pin_0_out,
   output logic general_pin_0_oe,
   input wire logic general_pin_1_in,
   output logic general_pin_1_out,
   output logic general_pin_1_oe,
   // General pin drive from the core
   input wire logic [1:0] gp_drive,
   input wire logic [1:0] gp_enable,
   // Graphics engine side
   input wire logic eng_fetch,
   input wire logic [11:0] eng_fetch_addr,
   output logic [7:0] eng_data,
   output logic eng_data_valid,
   input wire logic eng_retire,
   input wire logic [11:0] eng_retire_bytes,
   // Ring status
   output logic cmd_pending,
   output logic [11:0] cmd_wr_ptr,
   output logic [11:0] cmd_rd_ptr,
   output logic [1:0] lane_width
);
   logic [7:0] ring [FIFO_BYTES];
   logic sck_m, sck_s, sck_d, cs_m, cs_s;
   logic [3:0] din_m, din_s;
   hspc_state_e state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt, step, cnt_sum;
   logic [7:0] sh_r, sh_nxt, sh_in, tx_r, tx_nxt, host_rdata;
   logic [14:0] addr_r, addr_nxt;
   logic is_wr_r, is_wr_nxt;
   logic [1:0] act_w_r, act_w_nxt, lane_width_r, lane_width_nxt;
   logic rise, fall, sel, byte_done, host_wr;
   logic [11:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt, retire_n;
   logic [7:0] wr_hold_r, wr_hold_nxt, eng_data_r, eng_data_nxt;
   logic pending_r, pending_nxt, eng_valid_r, eng_valid_nxt;
   logic [3:0] pin_out_r, pin_out_nxt, pin_oe_r, pin_oe_nxt;
   logic quad_pins;

   // Two-stage synchronisers; sck gets a third stage for edge finding
   always_ff @(posedge clock) begin
      sck_m <= sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      cs_m <= cs_n;
      cs_s <= cs_m;
      din_m <= {general_pin_1_in, general_pin_0_in, data_lane_1_in, data_lane_0_in};
      din_s <= din_m;
   end

   assign rise = sck_s & ~sck_d;
   assign fall = ~sck_s & sck_d;
   assign sel = ~cs_s;
   assign step = hspc_lane_step(act_w_r);
   assign cnt_sum = 4'(cnt_r + step);
   assign byte_done = rise && (cnt_sum == BYTE_BITS);

   always_comb begin
      case (act_w_r)
         LANE_QUAD: sh_in = {sh_r[3:0], din_s[3:0]};
         LANE_DUAL: sh_in = {sh_r[5:0], din_s[1:0]};
         default: sh_in = {sh_r[6:0], din_s[0]};
      endcase
      if (addr_r == REG_LANE_WIDTH) begin
         host_rdata = {6'h00, lane_width_r};
      end else if (addr_r == REG_CMD_WR_LO) begin
         host_rdata = wr_ptr_r[7:0];
      end else if (addr_r == REG_CMD_WR_HI) begin
         host_rdata = {4'h0, wr_ptr_r[11:8]};
      end else if (addr_r == REG_CMD_RD_LO) begin
         host_rdata = rd_ptr_r[7:0];
      end else if (addr_r == REG_CMD_RD_HI) begin
         host_rdata = {4'h0, rd_ptr_r[11:8]};
      end else if (addr_r[14:12] == FIFO_REGION) begin
         host_rdata = ring[addr_r[11:0]];
      end else begin
         host_rdata = 8'h00;
      end
   end

   // Transaction sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      addr_nxt = addr_r;
      is_wr_nxt = is_wr_r;
      act_w_nxt = act_w_r;
      host_wr = 1'b0;
      if (state_r == ST_IDLE) begin
         if (sel) begin
            // Width is latched per frame so a width write takes effect next frame
            act_w_nxt = lane_width_r;
            state_nxt = ST_ADDR_HI;
            cnt_nxt = 4'h0;
            tx_nxt = 8'h00;
         end
      end else if (!sel) begin
         state_nxt = ST_IDLE;
      end else if (rise) begin
         sh_nxt = sh_in;
         cnt_nxt = byte_done ? 4'h0 : cnt_sum;
         if (byte_done) begin
            case (state_r)
               ST_ADDR_HI: begin
                  is_wr_nxt = sh_in[CMD_WRITE_BIT];
                  addr_nxt = {sh_in[6:0], addr_r[7:0]};
                  state_nxt = ST_ADDR_LO;
               end
               ST_ADDR_LO: begin
                  addr_nxt = {addr_r[14:8], sh_in};
                  state_nxt = is_wr_r ? ST_WDATA : ST_DUMMY;
               end
               ST_DUMMY, ST_RDATA: begin
                  tx_nxt = host_rdata;
                  addr_nxt = 15'(addr_r + 15'h0001);
                  state_nxt = ST_RDATA;
               end
               ST_WDATA: begin
                  host_wr = 1'b1;
                  addr_nxt = 15'(addr_r + 15'h0001);
               end
               default: state_nxt = ST_IDLE;
            endcase
         end
      end else if (fall && cnt_r != 4'h0) begin
         // First falling edge of a byte must not shift the freshly loaded byte
         tx_nxt = 8'(tx_r << step);
      end
   end

   // Register file and ring pointers
   always_comb begin
      lane_width_nxt = lane_width_r;
      wr_hold_nxt = wr_hold_r;
      wr_ptr_nxt = wr_ptr_r;
      if (host_wr && addr_r == REG_LANE_WIDTH) begin
         lane_width_nxt = sh_in[1:0];
      end else if (host_wr && addr_r == REG_CMD_WR_LO) begin
         wr_hold_nxt = sh_in;
      end else if (host_wr && addr_r == REG_CMD_WR_HI) begin
         // High byte commits so the engine never sees a half-updated pointer
         wr_ptr_nxt = {sh_in[3:0], wr_hold_r};
      end
      // Retire is clamped to the fill level so the read side cannot pass the write side
      retire_n = (eng_retire_bytes > hspc_fill(wr_ptr_r, rd_ptr_r)) ? hspc_fill(wr_ptr_r, rd_ptr_r)
                                                                 : eng_retire_bytes;
      rd_ptr_nxt = eng_retire ? 12'(rd_ptr_r + retire_n) : rd_ptr_r;
      pending_nxt = (wr_ptr_nxt != rd_ptr_nxt);
      eng_valid_nxt = eng_fetch;
      eng_data_nxt = eng_fetch ? ring[eng_fetch_addr] : eng_data_r;
   end

   // Pin drive; outputs follow tx_nxt so they line up with the shifter
   assign quad_pins = (lane_width_r == LANE_QUAD) || (act_w_r == LANE_QUAD && state_r != ST_IDLE);
   always_comb begin
      pin_out_nxt = 4'h0;
      pin_oe_nxt = 4'h0;
      if (act_w_r == LANE_QUAD) begin
         pin_out_nxt = tx_nxt[7:4];
         pin_oe_nxt = (state_nxt == ST_RDATA) ? 4'hF : 4'h0;
      end else if (act_w_r == LANE_DUAL) begin
         pin_out_nxt = {2'h0, tx_nxt[7:6]};
         pin_oe_nxt = (state_nxt == ST_RDATA) ? 4'h3 : 4'h0;
      end else begin
         pin_out_nxt = {2'h0, tx_nxt[7], 1'b0};
         pin_oe_nxt = {2'h0, state_nxt != ST_IDLE, 1'b0};
      end
      if (!quad_pins) begin
         pin_out_nxt[3:2] = gp_drive;
         pin_oe_nxt[3:2] = gp_enable;
      end
   end

   always_ff @(posedge clock) begin
      if (host_wr && addr_r[14:12] == FIFO_REGION) begin
         ring[addr_r[11:0]] <= sh_in;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         addr_r <= 15'h0000;
         is_wr_r <= 1'b0;
         act_w_r <= LANE_RESET;
         lane_width_r <= LANE_RESET;
         wr_hold_r <= 8'h00;
         wr_ptr_r <= PTR_RESET;
         rd_ptr_r <= PTR_RESET;
         pending_r <= 1'b0;
         eng_valid_r <= 1'b0;
         eng_data_r <= 8'h00;
         pin_out_r <= 4'h0;
         pin_oe_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         addr_r <= addr_nxt;
         is_wr_r <= is_wr_nxt;
         act_w_r <= act_w_nxt;
         lane_width_r <= lane_width_nxt;
         wr_hold_r <= wr_hold_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         pending_r <= pending_nxt;
         eng_valid_r <= eng_valid_nxt;
         eng_data_r <= eng_data_nxt;
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign data_lane_0_out = pin_out_r[0];
   assign data_lane_1_out = pin_out_r[1];
   assign general_pin_0_out = pin_out_r[2];
   assign general_pin_1_out = pin_out_r[3];
   assign data_lane_0_oe = pin_oe_r[0];
   assign data_lane_1_oe = pin_oe_r[1];
   assign general_pin_0_oe = pin_oe_r[2];
   assign general_pin_1_oe = pin_oe_r[3];
   assign eng_data = eng_data_r;
   assign eng_data_valid = eng_valid_r;
   assign cmd_pending = pending_r;
   assign cmd_wr_ptr = wr_ptr_r;
   assign cmd_rd_ptr = rd_ptr_r;
   assign lane_width = lane_width_r;

   a_reset_single: assert property (@(posedge clock) srst |=> lane_width_r == LANE_SINGLE && !data_lane_0_oe)
      else $error("width not single after reset");
   a_single_no_lane0: assert property (@(posedge clock) disable iff (srst) act_w_r == LANE_SINGLE |=> !data_lane_0_oe)
      else $error("lane 0 driven in single mode");
   a_width_write: assert property (@(posedge clock) disable iff (srst)
      host_wr && addr_r == REG_LANE_WIDTH |=> lane_width_r == $past(sh_in[1:0]))
      else $error("width write lost");
   a_width_step: assert property (@(posedge clock) disable iff (srst)
      rise && sel && state_r != ST_IDLE && act_w_r == LANE_QUAD |=> sh_r[3:0] == $past(din_s[3:0]))
      else $error("lane step decode wrong");
   a_fetch_ring: assert property (@(posedge clock) disable iff (srst)
      eng_fetch |=> eng_data_valid && eng_data == $past(ring[eng_fetch_addr]))
      else $error("engine fetch data wrong");
   a_wr_commit: assert property (@(posedge clock) disable iff (srst)
      host_wr && addr_r == REG_CMD_WR_HI |=> cmd_wr_ptr == {$past(sh_in[3:0]), $past(wr_hold_r)})
      else $error("write pointer not committed");
   a_rd_retire_only: assert property (@(posedge clock) disable iff (srst)
      !eng_retire |=> $stable(cmd_rd_ptr))
      else $error("read pointer moved without retire");
   a_empty_equal: assert property (@(posedge clock) disable iff (srst)
      ##1 cmd_pending == (cmd_wr_ptr != cmd_rd_ptr))
      else $error("pending flag disagrees with pointers");
   a_deselect_idle: assert property (@(posedge clock) disable iff (srst)
      cs_s && state_r != ST_IDLE |=> state_r == ST_IDLE ##1 !data_lane_1_oe)
      else $error("port active while deselected");
   a_gp_pass: assert property (@(posedge clock) disable iff (srst)
      !quad_pins |=> general_pin_0_out == $past(gp_drive[0]) && general_pin_1_oe == $past(gp_enable[1]))
      else $error("general pins not passed through");
endmodule

// ### verif/hspc_host.sv
// Host serial master model: select, clock and data lanes
`timescale 1ns/10ps
module hspc_host (
   // Pins driven by the host
   output logic sck,
   output logic cs_n,
   output logic [3:0] hv,
   output logic [3:0] h_oe,
   // Resolved lane levels
   input wire logic [3:0] lane
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      hv = 4'h0;
      h_oe = 4'h0;
   end
   // Select low for the whole frame, clock idles low
   task automatic start();
      cs_n = 1'b0;
      #400;
   endtask
   task automatic stop();
      #100;
      cs_n = 1'b1;
      h_oe = 4'h0;
      #400;
   endtask
   // 200 ns period, far below the 25MHz quad limit
   task automatic xb(input logic [3:0] step, input logic [7:0] tx, input logic drv, output logic [7:0] rx);
      logic [7:0] s;
      s = tx;
      rx = 8'h00;
      repeat (8 / step) begin
         h_oe = drv ? ((4'h1 << step) - 4'h1) : 4'h0;
         hv = s[7:4] >> (4 - step);
         #100;
         sck = 1'b1;
         rx = (rx << step) | ((step == 4'h1) ? {7'h00, lane[1]} : {4'h0, lane & ((4'h1 << step) - 4'h1)});
         #100;
         sck = 1'b0;
         s = s << step;
      end
   endtask
endmodule

// ### verif/tb.sv
// Testbench for the host serial port and command ring
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
   import hspc_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [1:0] gp_drive = 2'h2;
   logic [1:0] gp_enable = 2'h3;
   logic eng_fetch = 1'b0;
   logic [11:0] eng_fetch_addr = 12'h000;
   logic eng_retire = 1'b0;
   logic [11:0] eng_retire_bytes = 12'h000;
   logic sck, cs_n, eng_data_valid, cmd_pending;
   logic [3:0] hv, h_oe;
   wire [3:0] d_out, d_oe, lane;
   logic [7:0] eng_data;
   logic [11:0] cmd_wr_ptr, cmd_rd_ptr;
   logic [1:0] lane_width, cw;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   always #12.5 clock = ~clock;
   // Undriven lanes show the inverse of the last host bit, not a lucky value
   assign lane = (d_oe & d_out) | (~d_oe & ((h_oe & hv) | (~h_oe & ~hv)));
   hspc_port u_hspc_port (.clock(clock), .srst(srst), .sck(sck), .cs_n(cs_n),
      .data_lane_0_in(lane[0]), .data_lane_0_out(d_out[0]), .data_lane_0_oe(d_oe[0]),
      .data_lane_1_in(lane[1]), .data_lane_1_out(d_out[1]), .data_lane_1_oe(d_oe[1]),
      .general_pin_0_in(lane[2]), .general_pin_0_out(d_out[2]), .general_pin_0_oe(d_oe[2]),
      .general_pin_1_in(lane[3]), .general_pin_1_out(d_out[3]), .general_pin_1_oe(d_oe[3]),
      .gp_drive(gp_drive), .gp_enable(gp_enable), .eng_fetch(eng_fetch), .eng_fetch_addr(eng_fetch_addr),
      .eng_data(eng_data), .eng_data_valid(eng_data_valid), .eng_retire(eng_retire),
      .eng_retire_bytes(eng_retire_bytes), .cmd_pending(cmd_pending), .cmd_wr_ptr(cmd_wr_ptr),
      .cmd_rd_ptr(cmd_rd_ptr), .lane_width(lane_width));
   hspc_host u_hspc_host (.sck(sck), .cs_n(cs_n), .hv(hv), .h_oe(h_oe), .lane(lane));
   function automatic logic [3:0] stp(input logic [1:0] w);
      stp = (w == LANE_DUAL) ? 4'h2 : (w == LANE_QUAD) ? 4'h4 : 4'h1;
   endfunction
   // One frame: header, address, dummy on reads, one data byte
   task automatic xf(input logic we, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [7:0] r;
      @(posedge clock);
      #2;
      u_hspc_host.start();
      u_hspc_host.xb(stp(cw), {we, a[14:8]}, 1'b1, r);
      u_hspc_host.xb(stp(cw), a[7:0], 1'b1, r);
      if (!we) u_hspc_host.xb(stp(cw), 8'h00, 1'b1, r);
      u_hspc_host.xb(stp(cw), d, we, q);
      u_hspc_host.stop();
   endtask
   task automatic retire(input logic [11:0] n);
      @(posedge clock);
      #2;
      eng_retire = 1'b1;
      eng_retire_bytes = n;
      @(posedge clock);
      #2;
      eng_retire = 1'b0;
   endtask
   task automatic t_reset();
      `CHK("lane_width", LANE_SINGLE, lane_width)
      `CHK("pending", 1'b0, cmd_pending)
      `CHK("lane1_oe", 1'b0, d_oe[1])
      `CHK("lane0_oe", 1'b0, d_oe[0])
      `CHK("gp_out", 2'h2, d_out[3:2])
   endtask
   task automatic t_single();
      logic [7:0] q;
      xf(1'b1, 15'h0FFF, 8'hA5, q);
      xf(1'b0, 15'h0FFF, 8'h00, q);
      `CHK("ring_top", 8'hA5, q)
      @(posedge clock);
      #2;
      eng_fetch = 1'b1;
      eng_fetch_addr = 12'hFFF;
      @(posedge clock);
      #2;
      eng_fetch = 1'b0;
      `CHK("fetch_valid", 1'b1, eng_data_valid)
      `CHK("fetch_data", 8'hA5, eng_data)
      xf(1'b0, 15'h1F00, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
   endtask
   task automatic t_ignore();
      logic [7:0] q;
      @(posedge clock);
      #2;
      u_hspc_host.xb(4'h1, 8'h90, 1'b1, q);
      u_hspc_host.xb(4'h1, 8'h00, 1'b1, q);
      u_hspc_host.xb(4'h1, 8'h01, 1'b1, q);
      #400;
      `CHK("width_deselected", LANE_SINGLE, lane_width)
   endtask
   task automatic t_widths();
      logic [7:0] q;
      logic [1:0] w;
      for (int i = 1; i < 4; i++) begin
         w = 2'(i);
         xf(1'b1, REG_LANE_WIDTH, {6'h00, w}, q);
         // Reserved code keeps one lane
         cw = (w == LANE_RSVD) ? LANE_SINGLE : w;
         `CHK("lane_width", w, lane_width)
         xf(1'b0, REG_LANE_WIDTH, 8'h00, q);
         `CHK("width_read", {6'h00, w}, q)
         xf(1'b1, 15'h0020, 8'h5A ^ 8'(i), q);
         xf(1'b0, 15'h0020, 8'h00, q);
         `CHK("ring_byte", 8'h5A ^ 8'(i), q)
         `CHK("gp_oe", (w == LANE_QUAD) ? 2'h0 : 2'h3, d_oe[3:2])
      end
      xf(1'b1, REG_LANE_WIDTH, 8'h00, q);
      cw = LANE_SINGLE;
   endtask
   task automatic t_ring();
      logic [7:0] q;
      xf(1'b1, REG_CMD_WR_LO, 8'h05, q);
      `CHK("wr_lo_held", 12'h000, cmd_wr_ptr)
      xf(1'b1, REG_CMD_WR_HI, 8'h00, q);
      `CHK("wr_ptr", 12'h005, cmd_wr_ptr)
      `CHK("pending", 1'b1, cmd_pending)
      `CHK("rd_idle", 12'h000, cmd_rd_ptr)
      xf(1'b0, REG_CMD_WR_LO, 8'h00, q);
      `CHK("wr_lo_rd", 8'h05, q)
      retire(12'h003);
      `CHK("rd_ptr", 12'h003, cmd_rd_ptr)
      xf(1'b0, REG_CMD_RD_LO, 8'h00, q);
      `CHK("rd_lo", 8'h03, q)
      xf(1'b0, REG_CMD_RD_HI, 8'h00, q);
      `CHK("rd_hi", 8'h00, q)
      retire(12'h00A);
      `CHK("rd_clamp", 12'h005, cmd_rd_ptr)
      `CHK("empty", 1'b0, cmd_pending)
      xf(1'b1, REG_CMD_WR_LO, 8'h01, q);
      xf(1'b1, REG_CMD_WR_HI, 8'h00, q);
      retire(12'hFFC);
      `CHK("rd_wrap", 12'h001, cmd_rd_ptr)
      `CHK("wrap_empty", 1'b0, cmd_pending)
   endtask
   // Mid-run reset must clear width and both pointers, and the port must work after it
   task automatic t_midreset();
      logic [7:0] q;
      xf(1'b1, REG_LANE_WIDTH, 8'h01, q);
      `CHK("pre_rst_width", LANE_DUAL, lane_width)
      @(posedge clock);
      #2;
      srst = 1'b1;
      repeat (4) @(posedge clock);
      #2;
      srst = 1'b0;
      repeat (4) @(posedge clock);
      `CHK("rst_width", LANE_SINGLE, lane_width)
      `CHK("rst_wr_ptr", PTR_RESET, cmd_wr_ptr)
      `CHK("rst_rd_ptr", PTR_RESET, cmd_rd_ptr)
      `CHK("rst_pending", 1'b0, cmd_pending)
      xf(1'b0, REG_CMD_RD_LO, 8'h00, q);
      `CHK("rst_rd_lo", 8'h00, q)
   endtask
   task automatic summarize();
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      cw = LANE_SINGLE;
      repeat (10) @(posedge clock);
      #2;
      srst = 1'b0;
      repeat (4) @(posedge clock);
      t_reset();
      t_single();
      t_ignore();
      t_widths();
      t_ring();
      t_midreset();
      summarize();
   end
endmodule
